// ===== port_phy_regs_pkg.sv
// Constants and types for the per-port PHY control and status register bank
package port_phy_regs_pkg;
  // Bus geometry
  localparam int APB_ADDR_W = 12;
  localparam int APB_DATA_W = 32;
  localparam int NUM_PORTS = 2;
  localparam int ADV_W = 4;
  localparam int SYNC_W = 13;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_P1_LINK_STATUS_ZERO = 8'h29;
  localparam logic [7:0] IDX_P1_PHY_SPECIAL_CTRL = 8'h2a;
  localparam logic [7:0] IDX_P1_NEGOTIATION_CTRL = 8'h2c;
  localparam logic [7:0] IDX_P2_LINK_STATUS_ZERO = 8'h39;
  localparam logic [7:0] IDX_P2_PHY_SPECIAL_CTRL = 8'h3a;
  localparam logic [7:0] IDX_P2_NEGOTIATION_CTRL = 8'h3c;
  localparam logic [7:0] IDX_REDUCED_MII_CLOCK_CTRL = 8'h57;
  // Link status zero fields
  localparam int STAT0_XOVER_BIT = 7;
  localparam int STAT0_POL_BIT = 5;
  localparam int STAT0_TXFC_BIT = 4;
  localparam int STAT0_RXFC_BIT = 3;
  localparam int STAT0_SPEED_BIT = 2;
  localparam int STAT0_DUPLEX_BIT = 1;
  localparam logic [7:0] STAT0_WMASK = 8'h80;
  localparam logic [7:0] STAT0_RESET = 8'h80;
  // PHY special control fields
  localparam int SPEC_FORCE_LINK_BIT = 3;
  localparam int SPEC_PWRSAVE_BIT = 2;
  localparam int SPEC_RLOOP_BIT = 1;
  localparam logic [7:0] SPEC_WMASK = 8'h0e;
  localparam logic [7:0] SPEC_RESET = 8'h00;
  // Negotiation control fields
  localparam int NEG_AN_DIS_BIT = 7;
  localparam int NEG_FSPEED_BIT = 6;
  localparam int NEG_FDUPLEX_BIT = 5;
  localparam int NEG_ADV_FC_BIT = 4;
  localparam logic [7:0] NEG_WMASK = 8'hff;
  localparam logic [7:0] NEG_RESET = 8'h5f;
  // Reduced-MII clock control fields
  localparam int RMII_CLK_DIS_BIT = 3;
  localparam logic [7:0] RMII_WMASK = 8'h08;
  localparam logic [7:0] RMII_RESET = 8'h00;
  // Register selection
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_STAT0_P1,
    SEL_SPEC_P1,
    SEL_NEG_P1,
    SEL_STAT0_P2,
    SEL_SPEC_P2,
    SEL_NEG_P2,
    SEL_RMII
  } reg_sel_t;
endpackage : port_phy_regs_pkg

// ===== port_phy_control_status_regs.sv
// Per-port PHY control and status register bank with APB slave
//
// Notes on behaviour
// - Clock-disable bit set stops driving the reduced-MII clock on the receive clock pin.
// - Crossover algorithm select is read/write, resets to one.
// - Status bit five reads one when receive polarity is reversed.
// - Status bit four reads one while transmit flow control is active.
// - Status bit three reads one while receive flow control is active.
// - Status bit two reads one at 100 Mbit/s, zero at 10.
// - Status bit one reads one at full duplex, zero at half.
// - Force-link bit makes the PHY treat the link as passing; resets zero.
// - Power-saving bit enables PHY power saving; resets zero.
// - Remote loopback bit loops line receive data back to line transmit.
// - Negotiation-disable bit turns auto-negotiation off, using forced speed and duplex.
// - With negotiation off, forced-speed bit picks 100 or 10 Mbit/s; resets one.
// - Forced duplex applies when negotiation is off or has failed.
// - Flow-control advertise bit offers flow control to the partner; resets one.
// - Bits three to zero advertise the four speed/duplex abilities; reset one.
//
// Local design decision: register access over APB.
module port_phy_control_status_regs (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic [port_phy_regs_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [port_phy_regs_pkg::APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [port_phy_regs_pkg::APB_DATA_W-1:0] prdata,
  output wire logic pready,
  output wire logic pslverr,
  // PHY status, asynchronous
  input wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] phy_polarity_reversed,
  input wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] phy_tx_flow_active,
  input wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] phy_rx_flow_active,
  input wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] phy_speed_100,
  input wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] phy_full_duplex,
  input wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] phy_an_failed,
  // Fourth port mode strap, asynchronous
  input wire logic port_four_reduced_mii,
  // PHY controls
  output wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] crossover_algorithm_select,
  output wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] force_link_pass,
  output wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] power_save_en,
  output wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] remote_loopback_en,
  output wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] an_enable,
  output wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] advertise_flow_ctrl,
  output wire logic [port_phy_regs_pkg::NUM_PORTS*port_phy_regs_pkg::ADV_W-1:0] advertise_abilities,
  output wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] link_speed_100,
  output wire logic [port_phy_regs_pkg::NUM_PORTS-1:0] link_full_duplex,
  // Reduced-MII clock drive
  output wire logic receive_clock_pin_oe
);
  import port_phy_regs_pkg::*;

  function automatic logic [7:0] masked_write(input logic [7:0] old_v, input logic [7:0] wd,
                                              input logic [7:0] mask);
    masked_write = (old_v & ~mask) | (wd & mask);
  endfunction : masked_write

  function automatic logic [7:0] status0_word(input logic xover, input logic pol,
                                              input logic txfc, input logic rxfc,
                                              input logic spd, input logic dup);
    status0_word = 8'h00;
    status0_word[STAT0_XOVER_BIT] = xover;
    status0_word[STAT0_POL_BIT] = pol;
    status0_word[STAT0_TXFC_BIT] = txfc;
    status0_word[STAT0_RXFC_BIT] = rxfc;
    status0_word[STAT0_SPEED_BIT] = spd;
    status0_word[STAT0_DUPLEX_BIT] = dup;
  endfunction : status0_word

  // Input synchronisers
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic [NUM_PORTS-1:0] pol_s;
  logic [NUM_PORTS-1:0] txfc_s;
  logic [NUM_PORTS-1:0] rxfc_s;
  logic [NUM_PORTS-1:0] spd_s;
  logic [NUM_PORTS-1:0] dup_s;
  logic [NUM_PORTS-1:0] anf_s;
  logic strap_s;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {port_four_reduced_mii, phy_an_failed, phy_full_duplex, phy_speed_100,
                 phy_rx_flow_active, phy_tx_flow_active, phy_polarity_reversed};
      sync_q <= meta_q;
    end
  end

  assign pol_s = sync_q[1:0];
  assign txfc_s = sync_q[3:2];
  assign rxfc_s = sync_q[5:4];
  assign spd_s = sync_q[7:6];
  assign dup_s = sync_q[9:8];
  assign anf_s = sync_q[11:10];
  assign strap_s = sync_q[12];

  // Address decode
  logic [7:0] word_idx;
  logic aligned;
  reg_sel_t sel;
  logic setup;
  logic wr_en;

  assign word_idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pstrb[0] && (sel != SEL_NONE);

  always_comb begin
    sel = SEL_NONE;
    if (aligned) begin
      case (word_idx)
        IDX_P1_LINK_STATUS_ZERO: sel = SEL_STAT0_P1;
        IDX_P1_PHY_SPECIAL_CTRL: sel = SEL_SPEC_P1;
        IDX_P1_NEGOTIATION_CTRL: sel = SEL_NEG_P1;
        IDX_P2_LINK_STATUS_ZERO: sel = SEL_STAT0_P2;
        IDX_P2_PHY_SPECIAL_CTRL: sel = SEL_SPEC_P2;
        IDX_P2_NEGOTIATION_CTRL: sel = SEL_NEG_P2;
        IDX_REDUCED_MII_CLOCK_CTRL: sel = SEL_RMII;
        default: sel = SEL_NONE;
      endcase
    end
  end

  // Register storage
  logic [7:0] stat0_q [NUM_PORTS];
  logic [7:0] spec_q [NUM_PORTS];
  logic [7:0] neg_q [NUM_PORTS];
  logic [7:0] rmii_q;
  logic clk_oe_q;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam reg_sel_t S_STAT0 = (p == 0) ? SEL_STAT0_P1 : SEL_STAT0_P2;
    localparam reg_sel_t S_SPEC = (p == 0) ? SEL_SPEC_P1 : SEL_SPEC_P2;
    localparam reg_sel_t S_NEG = (p == 0) ? SEL_NEG_P1 : SEL_NEG_P2;
    logic speed_q;
    logic duplex_q;

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        stat0_q[p] <= STAT0_RESET;
      end else if (wr_en && sel == S_STAT0) begin
        stat0_q[p] <= masked_write(stat0_q[p], pwdata[7:0], STAT0_WMASK);
      end
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        spec_q[p] <= SPEC_RESET;
      end else if (wr_en && sel == S_SPEC) begin
        spec_q[p] <= masked_write(spec_q[p], pwdata[7:0], SPEC_WMASK);
      end
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        neg_q[p] <= NEG_RESET;
      end else if (wr_en && sel == S_NEG) begin
        neg_q[p] <= masked_write(neg_q[p], pwdata[7:0], NEG_WMASK);
      end
    end

    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        speed_q <= NEG_RESET[NEG_FSPEED_BIT];
        duplex_q <= NEG_RESET[NEG_FDUPLEX_BIT];
      end else begin
        speed_q <= neg_q[p][NEG_AN_DIS_BIT] ? neg_q[p][NEG_FSPEED_BIT] : spd_s[p];
        duplex_q <= (neg_q[p][NEG_AN_DIS_BIT] || anf_s[p]) ?
                    neg_q[p][NEG_FDUPLEX_BIT] : dup_s[p];
      end
    end

    assign crossover_algorithm_select[p] = stat0_q[p][STAT0_XOVER_BIT];
    assign force_link_pass[p] = spec_q[p][SPEC_FORCE_LINK_BIT];
    assign power_save_en[p] = spec_q[p][SPEC_PWRSAVE_BIT];
    assign remote_loopback_en[p] = spec_q[p][SPEC_RLOOP_BIT];
    assign an_enable[p] = !neg_q[p][NEG_AN_DIS_BIT];
    assign advertise_flow_ctrl[p] = neg_q[p][NEG_ADV_FC_BIT];
    assign advertise_abilities[ADV_W*p +: ADV_W] = neg_q[p][ADV_W-1:0];
    assign link_speed_100[p] = speed_q;
    assign link_full_duplex[p] = duplex_q;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rmii_q <= RMII_RESET;
    end else if (wr_en && sel == SEL_RMII) begin
      rmii_q <= masked_write(rmii_q, pwdata[7:0], RMII_WMASK);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clk_oe_q <= 1'b0;
    end else begin
      clk_oe_q <= strap_s && !rmii_q[RMII_CLK_DIS_BIT];
    end
  end

  assign receive_clock_pin_oe = clk_oe_q;

  // Read path, captured in setup phase
  logic [7:0] rd_word;

  always_comb begin
    rd_word = 8'h00;
    case (sel)
      SEL_STAT0_P1: rd_word = status0_word(stat0_q[0][STAT0_XOVER_BIT], pol_s[0], txfc_s[0],
                                           rxfc_s[0], spd_s[0], dup_s[0]);
      SEL_SPEC_P1: rd_word = spec_q[0];
      SEL_NEG_P1: rd_word = neg_q[0];
      SEL_STAT0_P2: rd_word = status0_word(stat0_q[1][STAT0_XOVER_BIT], pol_s[1], txfc_s[1],
                                           rxfc_s[1], spd_s[1], dup_s[1]);
      SEL_SPEC_P2: rd_word = spec_q[1];
      SEL_NEG_P2: rd_word = neg_q[1];
      SEL_RMII: rd_word = rmii_q;
      default: rd_word = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= {24'h000000, rd_word};
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel == SEL_NONE);

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  rmii_clock_gate_a: assert property (rmii_q[RMII_CLK_DIS_BIT] |=> !receive_clock_pin_oe)
    else $error("receive clock driven while disabled");
  xover_write_a: assert property (wr_en && sel == SEL_STAT0_P1 |=>
    crossover_algorithm_select[0] == $past(pwdata[STAT0_XOVER_BIT]))
    else $error("crossover select not written");
  polarity_read_a: assert property (setup && sel == SEL_STAT0_P1 |=>
    prdata[STAT0_POL_BIT] == $past(pol_s[0]))
    else $error("polarity status wrong");
  txfc_read_a: assert property (setup && sel == SEL_STAT0_P2 |=>
    prdata[STAT0_TXFC_BIT] == $past(txfc_s[1]))
    else $error("transmit flow status wrong");
  rxfc_read_a: assert property (setup && sel == SEL_STAT0_P1 |=>
    prdata[STAT0_RXFC_BIT] == $past(rxfc_s[0]))
    else $error("receive flow status wrong");
  speed_read_a: assert property (setup && sel == SEL_STAT0_P1 |=>
    prdata[STAT0_SPEED_BIT] == $past(spd_s[0]))
    else $error("speed status wrong");
  duplex_read_a: assert property (setup && sel == SEL_STAT0_P2 |=>
    prdata[STAT0_DUPLEX_BIT] == $past(dup_s[1]))
    else $error("duplex status wrong");
  force_link_a: assert property (wr_en && sel == SEL_SPEC_P1 |=>
    force_link_pass[0] == $past(pwdata[SPEC_FORCE_LINK_BIT]))
    else $error("force link not written");
  power_save_a: assert property (wr_en && sel == SEL_SPEC_P2 |=>
    power_save_en[1] == $past(pwdata[SPEC_PWRSAVE_BIT]))
    else $error("power save not written");
  remote_loop_a: assert property (wr_en && sel == SEL_SPEC_P1 |=>
    remote_loopback_en[0] == $past(pwdata[SPEC_RLOOP_BIT]))
    else $error("remote loopback not written");
  forced_speed_a: assert property (!an_enable[0] && $stable(neg_q[0]) |=>
    link_speed_100[0] == $past(neg_q[0][NEG_FSPEED_BIT]))
    else $error("forced speed not applied");
  forced_duplex_a: assert property (anf_s[0] && $stable(neg_q[0]) |=>
    link_full_duplex[0] == $past(neg_q[0][NEG_FDUPLEX_BIT]))
    else $error("forced duplex not applied");
  adv_flow_a: assert property (wr_en && sel == SEL_NEG_P2 |=>
    advertise_flow_ctrl[1] == $past(pwdata[NEG_ADV_FC_BIT]))
    else $error("flow advertisement not written");
  adv_abilities_a: assert property (wr_en && sel == SEL_NEG_P1 |=>
    advertise_abilities[ADV_W-1:0] == $past(pwdata[ADV_W-1:0]))
    else $error("abilities not written");
  reserved_zero_a: assert property (setup && sel == SEL_SPEC_P1 |=>
    prdata[7:4] == 4'h0 && !prdata[0] && prdata[31:8] == 24'h000000)
    else $error("reserved bits read nonzero");
  rmii_clock_drive_a: assert property (strap_s && !rmii_q[RMII_CLK_DIS_BIT] |=>
    receive_clock_pin_oe)
    else $error("receive clock not driven while enabled");
  xover_port_two_a: assert property (wr_en && sel == SEL_STAT0_P2 |=>
    crossover_algorithm_select[1] == $past(pwdata[STAT0_XOVER_BIT]))
    else $error("second port crossover select not written");
  force_link_two_a: assert property (wr_en && sel == SEL_SPEC_P2 |=>
    force_link_pass[1] == $past(pwdata[SPEC_FORCE_LINK_BIT]))
    else $error("second port force link not written");
  power_save_one_a: assert property (wr_en && sel == SEL_SPEC_P1 |=>
    power_save_en[0] == $past(pwdata[SPEC_PWRSAVE_BIT]))
    else $error("first port power save not written");
  an_speed_a: assert property (rstn && an_enable[1] |=>
    link_speed_100[1] == $past(spd_s[1]))
    else $error("negotiated speed not followed");
  off_duplex_a: assert property (!an_enable[1] |=>
    link_full_duplex[1] == $past(neg_q[1][NEG_FDUPLEX_BIT]))
    else $error("forced duplex not applied with negotiation off");
  an_duplex_a: assert property (rstn && an_enable[0] && !anf_s[0] |=>
    link_full_duplex[0] == $past(dup_s[0]))
    else $error("negotiated duplex not followed");
  refused_write_a: assert property (psel && penable && pwrite && !pstrb[0] |=>
    $stable(spec_q[0]) && $stable(neg_q[0]) && $stable(rmii_q))
    else $error("write without low strobe took effect");

  write_neg_c: cover property (wr_en && sel == SEL_NEG_P1 ##1 !an_enable[0]);
  read_status_c: cover property (setup && sel == SEL_STAT0_P2 ##1 psel && penable);
  clock_off_c: cover property (receive_clock_pin_oe ##1 !receive_clock_pin_oe);
  unmapped_c: cover property (pslverr);
  forced_link_c: cover property (!an_enable[1] ##1 link_speed_100[1]);
endmodule : port_phy_control_status_regs

// ===== port_phy_control_status_regs_tb_top.sv
// Self-checking testbench for the per-port PHY control and status register bank
module port_phy_control_status_regs_tb_top import port_phy_regs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [APB_DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] pol = 2'h0, txfc = 2'h0, rxfc = 2'h0, spd = 2'h0, dup = 2'h0, anf = 2'h0;
  logic strap = 1'b1;
  logic [1:0] xover, force_lnk, pwr, rloop, an_en, adv_fc, lspd, ldup;
  logic [7:0] abil;
  logic oe;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] idx_tab [7] = '{IDX_P1_LINK_STATUS_ZERO, IDX_P1_PHY_SPECIAL_CTRL,
    IDX_P1_NEGOTIATION_CTRL, IDX_P2_LINK_STATUS_ZERO, IDX_P2_PHY_SPECIAL_CTRL,
    IDX_P2_NEGOTIATION_CTRL, IDX_REDUCED_MII_CLOCK_CTRL};
  logic [7:0] rst_tab [7] = '{STAT0_RESET, SPEC_RESET, NEG_RESET, STAT0_RESET, SPEC_RESET,
    NEG_RESET, RMII_RESET};
  logic [7:0] msk_tab [7] = '{STAT0_WMASK, SPEC_WMASK, NEG_WMASK, STAT0_WMASK, SPEC_WMASK,
    NEG_WMASK, RMII_WMASK};

  port_phy_control_status_regs u_dut (
    .mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phy_polarity_reversed(pol), .phy_tx_flow_active(txfc),
    .phy_rx_flow_active(rxfc), .phy_speed_100(spd), .phy_full_duplex(dup),
    .phy_an_failed(anf), .port_four_reduced_mii(strap), .crossover_algorithm_select(xover),
    .force_link_pass(force_lnk), .power_save_en(pwr), .remote_loopback_en(rloop),
    .an_enable(an_en), .advertise_flow_ctrl(adv_fc), .advertise_abilities(abil),
    .link_speed_100(lspd), .link_full_duplex(ldup), .receive_clock_pin_oe(oe)
  );

  always #50 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : addr_of

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, addr_of(idx), {24'h0, d}, 4'hf);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, addr_of(idx), 32'h0, 4'h0);
    check("read data", rd, {24'h0, exp});
    check("read error", err, 1'b0);
  endtask : rd_chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    // Reset values at registers and outputs
    for (int i = 0; i < 7; i++) rd_chk(idx_tab[i], rst_tab[i]);
    check("ctrl rst", {xover, force_lnk, pwr, rloop, an_en, adv_fc, abil, oe}, 21'h181fff);
    check("link rst", {lspd, ldup}, 4'h0);
    $display("test reset values done");
    // All ones then all zeros; reserved and read-only bits stay zero
    for (int i = 0; i < 7; i++) wr(idx_tab[i], 8'hff);
    for (int i = 0; i < 7; i++) rd_chk(idx_tab[i], msk_tab[i]);
    check("ctrl ones", {xover, force_lnk, pwr, rloop, an_en, oe}, 11'h7f8);
    for (int i = 0; i < 7; i++) wr(idx_tab[i], 8'h00);
    for (int i = 0; i < 7; i++) rd_chk(idx_tab[i], 8'h00);
    check("ctrl zeros", {xover, force_lnk, pwr, rloop, an_en, oe}, 11'h007);
    for (int i = 0; i < 7; i++) wr(idx_tab[i], rst_tab[i]);
    $display("test access kinds done");
    // Status bits follow the line status, both patterns
    for (int p = 0; p < 2; p++) begin
      pol <= p ? 2'b10 : 2'b01;
      txfc <= p ? 2'b01 : 2'b10;
      rxfc <= p ? 2'b10 : 2'b01;
      spd <= p ? 2'b01 : 2'b10;
      dup <= p ? 2'b10 : 2'b01;
      repeat (3) @(posedge mclk);
      rd_chk(IDX_P1_LINK_STATUS_ZERO, p ? 8'h94 : 8'haa);
      rd_chk(IDX_P2_LINK_STATUS_ZERO, p ? 8'haa : 8'h94);
    end
    $display("test status bits done");
    // Resolved link with negotiation on, then failed, then forced
    spd <= 2'b01;
    dup <= 2'b11;
    anf <= 2'b00;
    repeat (4) @(posedge mclk);
    check("link an", {lspd, ldup}, 4'h7);
    anf <= 2'b01;
    repeat (4) @(posedge mclk);
    check("link an fail", {lspd, ldup}, 4'h6);
    wr(IDX_P1_NEGOTIATION_CTRL, 8'hba);
    wr(IDX_P2_NEGOTIATION_CTRL, 8'hc0);
    repeat (2) @(posedge mclk);
    check("link forced", {lspd, ldup}, 4'h9);
    check("advertise", {an_en, adv_fc, abil}, 12'h10a);
    $display("test link resolution done");
    // Clock pin drive follows the mode strap
    strap <= 1'b0;
    repeat (4) @(posedge mclk);
    check("clock off strap", oe, 1'b0);
    strap <= 1'b1;
    repeat (4) @(posedge mclk);
    check("clock on strap", oe, 1'b1);
    // Mid-run reset restores negotiation control reset values, negotiation back on
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd_chk(IDX_P1_NEGOTIATION_CTRL, NEG_RESET);
    rd_chk(IDX_P2_NEGOTIATION_CTRL, NEG_RESET);
    check("an after reset", an_en, 2'b11);
    $display("test strap and reset done");
    // Refused accesses
    apb(1'b0, addr_of(8'h28), 32'h0, 4'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, addr_of(IDX_P1_PHY_SPECIAL_CTRL) + 12'h1, 32'hff, 4'hf);
    check("misaligned err", err, 1'b1);
    apb(1'b1, addr_of(IDX_P1_PHY_SPECIAL_CTRL), 32'hff, 4'he);
    rd_chk(IDX_P1_PHY_SPECIAL_CTRL, 8'h00);
    $display("test refused accesses done");
    wrap_up();
  end
endmodule : port_phy_control_status_regs_tb_top
